// file: hw/dcs_pkg.sv
// Constants, types and register map of the downconverter-two control decoder
// Operation
// - Main code 100 (halfband one plus thirdband) decimates by 3 real, 6 complex.
// - Main code 101 (halfband one, two, thirdband) decimates by 6 real, 12 complex.
// - Main code 110 chains halfband one to three plus thirdband: 12 real, 24 complex.
// - Main code 111 hands the chain choice to the extended field, bits 7:4.
// - Extended field has effect only while the main selector is all ones.
// - Extended 0000 chains thirdband and four halfbands: 48 complex, 24 real.
// - Fifthband plus halfband one decimates by 10 complex, 5 real.
// - Extended 0011 chains fifthband, halfband two, one: 20 complex, 10 real.
// - Extended 0100 chains fifthband, halfband three to one: 40 complex, 20 real.
// - Mode 0000 takes the NCO channel from the register channel field.
// - Modes 0001 to 0110 build the channel index from listed pin levels.
// - Modes 1000 to 1011 count rising edges of pin a0, a1, b0, b1.
// - The edge counter counts up to the register channel field, then wraps to zero on the next edge.
// - In mode 0000 the register channel field picks the NCO channel by binary index; edge modes use it as the wrap limit.
// - Complex-to-real outputs I only, halving every decimation ratio.
package dcs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h350;
  localparam logic [9:0] IDX_INSEL = 10'h351;
  localparam logic [9:0] IDX_NCO = 10'h354;
  localparam logic [9:0] IDX_STAT = 10'h35f;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int CTRL_C2R_BIT = 3;
  localparam int INSEL_EXT_LSB = 4;
  localparam int INSEL_Q_BIT = 2;
  localparam int INSEL_I_BIT = 0;
  localparam int NCO_MODE_LSB = 4;
  // Main and extended chain codes
  localparam logic [2:0] MAIN_HB1_TB = 3'h4;
  localparam logic [2:0] MAIN_HB12_TB = 3'h5;
  localparam logic [2:0] MAIN_HB123_TB = 3'h6;
  localparam logic [2:0] MAIN_EXT = 3'h7;
  localparam logic [3:0] EXT_TB_HB4 = 4'h0;
  localparam logic [3:0] EXT_FB_HB1 = 4'h1;
  localparam logic [3:0] EXT_FB_HB1_ALT = 4'h2;
  localparam logic [3:0] EXT_FB_HB2 = 4'h3;
  localparam logic [3:0] EXT_FB_HB3 = 4'h4;
  // Complex-mode ratios
  localparam logic [5:0] RAT_6 = 6'h06;
  localparam logic [5:0] RAT_12 = 6'h0c;
  localparam logic [5:0] RAT_24 = 6'h18;
  localparam logic [5:0] RAT_48 = 6'h30;
  localparam logic [5:0] RAT_10 = 6'h0a;
  localparam logic [5:0] RAT_20 = 6'h14;
  localparam logic [5:0] RAT_40 = 6'h28;
  // Stage enables {fifthband, thirdband, hb4, hb3, hb2, hb1}
  localparam logic [5:0] STG_HB1_TB = 6'h11;
  localparam logic [5:0] STG_HB12_TB = 6'h13;
  localparam logic [5:0] STG_HB123_TB = 6'h17;
  localparam logic [5:0] STG_TB_HB4 = 6'h1f;
  localparam logic [5:0] STG_FB_HB1 = 6'h21;
  localparam logic [5:0] STG_FB_HB2 = 6'h23;
  localparam logic [5:0] STG_FB_HB3 = 6'h27;
  // NCO channel select modes
  localparam logic [3:0] MODE_REG = 4'h0;
  localparam logic [3:0] MODE_B0A0 = 4'h1;
  localparam logic [3:0] MODE_B1A1 = 4'h2;
  localparam logic [3:0] MODE_A1A0 = 4'h3;
  localparam logic [3:0] MODE_B1B0 = 4'h4;
  localparam logic [3:0] MODE_B1A1B0A0 = 4'h5;
  localparam logic [3:0] MODE_B1B0A1A0 = 4'h6;
  localparam logic [1:0] MODE_EDGE_TOP = 2'h2;
  // Pin vector positions
  localparam int GP_A0 = 0;
  localparam int GP_A1 = 1;
  localparam int GP_B0 = 2;
  localparam int GP_B1 = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic real_only;
    logic [5:0] ratio;
    logic [5:0] stages;
    logic q_sel;
    logic i_sel;
    logic [3:0] nco_chan;
  } dcs_decim_t;

  typedef struct packed {
    logic [2:0] main_sel;
    logic c2r;
    logic [3:0] ext_sel;
    logic q_sel;
    logic i_sel;
    logic [3:0] mode;
    logic [3:0] chan_field;
    logic [3:0] edge_cnt;
    logic [3:0] gp_prev;
    dcs_decim_t dec;
    logic aw_got;
    logic [9:0] aw_idx;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dcs_state_t;
endpackage

// file: hw/dcs_top.sv
// Downconverter-two decimation, input mux and NCO channel select control
//
// Chosen here: register access over AXI4-Lite.
module dcs_top
  import dcs_pkg::*;
(
  input wire logic ref_clk, // 40 MHz clock
  input wire logic srst, // Sync reset, high
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic gp_pin_a_zero, // Gp_pin_a_zero level
  input wire logic gp_pin_a_one, // Gp_pin_a_one level
  input wire logic gp_pin_b_zero, // Gp_pin_b_zero level
  input wire logic gp_pin_b_one, // Gp_pin_b_one level
  output dcs_decim_t decim_o // Decoded chain and channel
);

  dcs_state_t s_q;
  dcs_state_t s_d;
  logic [3:0] gp;
  logic [3:0] rise;

  assign gp = {gp_pin_b_one, gp_pin_b_zero, gp_pin_a_one, gp_pin_a_zero};
  assign rise = gp & ~s_q.gp_prev;

  // ----------------------------------------
  // Chain decode
  // ----------------------------------------
  function automatic dcs_decim_t chain(input logic [2:0] msel, input logic [3:0] esel,
                                       input logic c2r);
    dcs_decim_t r;
    r = '0;
    r.valid = 1'b1;
    case (msel)
      MAIN_HB1_TB:
      begin
        r.ratio = RAT_6;
        r.stages = STG_HB1_TB;
      end
      MAIN_HB12_TB:
      begin
        r.ratio = RAT_12;
        r.stages = STG_HB12_TB;
      end
      MAIN_HB123_TB:
      begin
        r.ratio = RAT_24;
        r.stages = STG_HB123_TB;
      end
      MAIN_EXT:
      begin
        // Extended field only consulted here
        case (esel)
          EXT_TB_HB4:
          begin
            r.ratio = RAT_48;
            r.stages = STG_TB_HB4;
          end
          EXT_FB_HB1, EXT_FB_HB1_ALT:
          begin
            r.ratio = RAT_10;
            r.stages = STG_FB_HB1;
          end
          EXT_FB_HB2:
          begin
            r.ratio = RAT_20;
            r.stages = STG_FB_HB2;
          end
          EXT_FB_HB3:
          begin
            r.ratio = RAT_40;
            r.stages = STG_FB_HB3;
          end
          default:
          begin
            r.valid = 1'b0;
          end
        endcase
      end
      default:
      begin
        r.valid = 1'b0;
      end
    endcase
    // Real output halves the complex ratio
    r.real_only = c2r;
    if (c2r)
    begin
      r.ratio = r.ratio >> 1;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Register readback
  // ----------------------------------------
  function automatic logic [31:0] read_word(input dcs_state_t s, input logic [9:0] idx);
    logic [31:0] v;
    v = '0;
    case (idx)
      IDX_CTRL: v[3:0] = {s.c2r, s.main_sel};
      IDX_INSEL:
      begin
        v[7:4] = s.ext_sel;
        v[INSEL_Q_BIT] = s.q_sel;
        v[INSEL_I_BIT] = s.i_sel;
      end
      IDX_NCO: v[7:0] = {s.mode, s.chan_field};
      IDX_STAT: v[23:0] = {s.edge_cnt, s.dec};
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    return idx == IDX_CTRL || idx == IDX_INSEL || idx == IDX_NCO || idx == IDX_STAT;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.w_byte = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.w_lane0)
      begin
        case (s_q.aw_idx)
          IDX_CTRL:
          begin
            s_d.main_sel = s_q.w_byte[2:0];
            s_d.c2r = s_q.w_byte[CTRL_C2R_BIT];
          end
          IDX_INSEL:
          begin
            s_d.ext_sel = s_q.w_byte[7:INSEL_EXT_LSB];
            s_d.q_sel = s_q.w_byte[INSEL_Q_BIT];
            s_d.i_sel = s_q.w_byte[INSEL_I_BIT];
          end
          IDX_NCO:
          begin
            s_d.mode = s_q.w_byte[7:NCO_MODE_LSB];
            s_d.chan_field = s_q.w_byte[3:0];
          end
          default:
          begin
            s_d.mode = s_q.mode;
          end
        endcase
      end
    end
    s_d.awready = !s_d.aw_got;
    s_d.wready = !s_d.w_got;
    // Read: one outstanding, answered the next cycle
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = read_word(s_q, s_axi_araddr[11:2]);
      s_d.rresp = mapped(s_axi_araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    // Chain and input routing
    s_d.dec = chain(s_q.main_sel, s_q.ext_sel, s_q.c2r);
    s_d.dec.q_sel = s_q.q_sel;
    s_d.dec.i_sel = s_q.i_sel;
    s_d.dec.nco_chan = s_q.dec.nco_chan;
    // NCO channel select
    s_d.gp_prev = gp;
    case (s_q.mode)
      MODE_REG: s_d.dec.nco_chan = s_q.chan_field;
      MODE_B0A0: s_d.dec.nco_chan = {2'h0, gp[GP_B0], gp[GP_A0]};
      MODE_B1A1: s_d.dec.nco_chan = {2'h0, gp[GP_B1], gp[GP_A1]};
      MODE_A1A0: s_d.dec.nco_chan = {2'h0, gp[GP_A1], gp[GP_A0]};
      MODE_B1B0: s_d.dec.nco_chan = {2'h0, gp[GP_B1], gp[GP_B0]};
      MODE_B1A1B0A0: s_d.dec.nco_chan = {gp[GP_B1], gp[GP_A1], gp[GP_B0], gp[GP_A0]};
      MODE_B1B0A1A0: s_d.dec.nco_chan = {gp[GP_B1], gp[GP_B0], gp[GP_A1], gp[GP_A0]};
      default:
      begin
        if (s_q.mode[3:2] == MODE_EDGE_TOP)
        begin
          if (rise[s_q.mode[1:0]])
          begin
            // Wrap after the field value
            s_d.edge_cnt = (s_q.edge_cnt >= s_q.chan_field) ? 4'h0 : s_q.edge_cnt + 4'h1;
          end
          s_d.dec.nco_chan = s_d.edge_cnt;
        end
        // Reserved codes hold the channel
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.dec.valid <= 1'b0;
      s_q.main_sel <= RST_REG[2:0];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign decim_o = s_q.dec;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_hb1_tb_ratio: assert property (s_q.main_sel == 3'h4 |=> decim_o.valid &&
    decim_o.ratio == ($past(s_q.c2r) ? 6'h03 : 6'h06)) else $error("hb1 tb ratio wrong");
  a_hb12_tb_ratio: assert property (s_q.main_sel == 3'h5 |=>
    decim_o.ratio == ($past(s_q.c2r) ? 6'h06 : 6'h0c)) else $error("hb12 tb ratio wrong");
  a_hb123_chain: assert property (s_q.main_sel == 3'h6 |=> decim_o.stages == 6'h17 &&
    decim_o.ratio == ($past(s_q.c2r) ? 6'h0c : 6'h18)) else $error("hb123 tb chain wrong");
  a_ext_ignored: assert property (s_q.main_sel != 3'h7 && $stable(s_q.main_sel) &&
    $stable(s_q.c2r) && $changed(s_q.ext_sel) |=> $stable(decim_o.ratio)) else $error("ext field leaked");
  a_ext_full_chain: assert property (s_q.main_sel == 3'h7 && s_q.ext_sel == 4'h0 |=>
    decim_o.ratio == ($past(s_q.c2r) ? 6'h18 : 6'h30)) else $error("ext 0 ratio wrong");
  a_ext_fb_hb3: assert property (s_q.main_sel == 3'h7 && s_q.ext_sel == 4'h4 |=>
    decim_o.stages == 6'h27 && decim_o.ratio == ($past(s_q.c2r) ? 6'h14 : 6'h28)) else $error("ext 4 wrong");
  a_reg_chan: assert property (s_q.mode == 4'h0 |=>
    decim_o.nco_chan == $past(s_q.chan_field)) else $error("register channel not applied");
  a_pin_chan: assert property (s_q.mode == 4'h5 |=> decim_o.nco_chan ==
    {$past(gp_pin_b_one), $past(gp_pin_a_one), $past(gp_pin_b_zero), $past(gp_pin_a_zero)})
    else $error("pin channel wrong");
  a_edge_wrap: assert property (s_q.mode == 4'h8 && rise[0] && s_q.edge_cnt >= s_q.chan_field
    |=> s_q.edge_cnt == 4'h0 && decim_o.nco_chan == 4'h0) else $error("edge counter no wrap");
  a_edge_step: assert property (s_q.mode == 4'hb && !rise[3] |=> $stable(s_q.edge_cnt))
    else $error("edge counter stepped without edge");
  a_reserved_hold: assert property (s_q.mode == 4'h7 |=> $stable(decim_o.nco_chan))
    else $error("reserved mode moved channel");
  a_input_route: assert property (##1 decim_o.q_sel == $past(s_q.q_sel) &&
    decim_o.i_sel == $past(s_q.i_sel)) else $error("input routing wrong");
  a_ext_fb_hb1: assert property (s_q.main_sel == 3'h7 && s_q.ext_sel inside {4'h1, 4'h2} |=>
    decim_o.stages == 6'h21 && decim_o.ratio == ($past(s_q.c2r) ? 6'h05 : 6'h0a))
    else $error("ext fifthband hb1 wrong");
  a_ext_fb_hb2: assert property (s_q.main_sel == 3'h7 && s_q.ext_sel == 4'h3 |=>
    decim_o.stages == 6'h23 && decim_o.ratio == ($past(s_q.c2r) ? 6'h0a : 6'h14))
    else $error("ext fifthband hb2 wrong");
  a_ext_handoff: assert property (s_q.main_sel == 3'h7 && s_q.ext_sel > 4'h4 |=> !decim_o.valid)
    else $error("unlisted ext code decoded");
  a_hb1_stages: assert property (s_q.main_sel == 3'h4 |=> decim_o.stages == 6'h11)
    else $error("hb1 tb stages wrong");
  a_hb12_stages: assert property (s_q.main_sel == 3'h5 |=> decim_o.stages == 6'h13)
    else $error("hb12 tb stages wrong");
  a_main_low: assert property (s_q.main_sel < 3'h4 |=> !decim_o.valid)
    else $error("lower main code decoded");
  a_real_flag: assert property (##1 decim_o.real_only == $past(s_q.c2r))
    else $error("real only flag wrong");

  a_chan_index: assert property (s_q.mode == 4'h0 && s_q.chan_field == 4'h1 |=> decim_o.nco_chan == 4'h1)
    else $error("channel index wrong");
  a_pin_pair: assert property (s_q.mode == 4'h1 |=>
    decim_o.nco_chan == {2'h0, $past(gp_pin_b_zero), $past(gp_pin_a_zero)}) else $error("two pin channel wrong");
  a_edge_count: assert property (s_q.mode == 4'h8 && rise[0] && s_q.edge_cnt < s_q.chan_field
    |=> s_q.edge_cnt == $past(s_q.edge_cnt) + 4'h1 && decim_o.nco_chan == s_q.edge_cnt)
    else $error("edge counter did not step");
  a_edge_show: assert property (s_q.mode == 4'h9 |=> decim_o.nco_chan == s_q.edge_cnt)
    else $error("edge count not shown");
  a_edge_other: assert property (s_q.mode == 4'h8 && !rise[0] |=> $stable(s_q.edge_cnt))
    else $error("edge counter stepped on idle pin");
  a_edge_idle: assert property (s_q.mode[3:2] != 2'h2 |=> $stable(s_q.edge_cnt))
    else $error("edge counter moved outside edge modes");
  a_reserved_high: assert property (s_q.mode[3:2] == 2'h3 |=> $stable(decim_o.nco_chan))
    else $error("upper reserved mode moved channel");

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  a_read_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
  a_rvalid_one: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_arready_back: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
    else $error("read address not reopened");
  a_bvalid_one: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h352 |=>
    s_axi_rvalid && s_axi_rresp == 2'h2) else $error("unmapped read not refused");

  c_edge_wrap: cover property (s_q.mode == 4'h9 && rise[1] && s_q.edge_cnt == s_q.chan_field);
  c_ext_fb: cover property (s_q.main_sel == 3'h7 && s_q.ext_sel == 4'h3 && s_q.c2r);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_strobe_off: cover property (s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'h0);

endmodule

// file: tb/dcs_gpio_model.sv
// External pin driver standing in for the board logic on the GPIO pins
module dcs_gpio_model
(
  input wire logic ref_clk, // Clock
  input wire logic [3:0] lvl, // Wanted levels {b1,b0,a1,a0}
  output logic gp_pin_a_zero = 1'b0, // Gp_pin_a_zero
  output logic gp_pin_a_one = 1'b0, // Gp_pin_a_one
  output logic gp_pin_b_zero = 1'b0, // Gp_pin_b_zero
  output logic gp_pin_b_one = 1'b0 // Gp_pin_b_one
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins move one edge after a request, like a registered board driver
  always_ff @(posedge ref_clk)
  begin
    {gp_pin_b_one, gp_pin_b_zero, gp_pin_a_one, gp_pin_a_zero} <= lvl; // levels and edges
  end
endmodule

// file: tb/test_dcs_top.sv
// Self-checking bench for the downconverter-two control decoder
module test_dcs_top import dcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] lvl = 4'h0;
  logic [3:0] wstrb = 4'h1;
  logic a0, a1, b0, b1;
  dcs_decim_t decim_o;
  int n_fail = 0;
  int checks = 0;
  logic [3:0] ecnt = 4'h0;
  logic [5:0] ratio;
  logic [2:0] t_main [8] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
  logic [3:0] t_ext [8] = '{4'h1, 4'h1, 4'h1, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
  logic [5:0] t_rat [8] = '{6'h06, 6'h0c, 6'h18, 6'h30, 6'h0a, 6'h0a, 6'h14, 6'h28};
  logic [5:0] t_stg [8] = '{STG_HB1_TB, STG_HB12_TB, STG_HB123_TB, STG_TB_HB4, STG_FB_HB1, STG_FB_HB1,
    STG_FB_HB2, STG_FB_HB3};
  logic [3:0] t_pat [2] = '{4'hb, 4'h6};

  dcs_top dcs_top_i (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gp_pin_a_zero(a0),
    .gp_pin_a_one(a1), .gp_pin_b_zero(b0), .gp_pin_b_one(b1), .decim_o(decim_o));
  dcs_gpio_model dcs_gpio_model_i (.ref_clk(ref_clk), .lvl(lvl), .gp_pin_a_zero(a0), .gp_pin_a_one(a1),
    .gp_pin_b_zero(b0), .gp_pin_b_one(b1));

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        break;
      end
    end
  endtask

  task automatic pulse(input int p);
    @(posedge ref_clk);
    lvl[p] <= 1'b1;
    cyc(4);
    lvl[p] <= 1'b0;
    cyc(4);
  endtask

  function automatic logic [3:0] pin_idx(input logic [3:0] m, input logic [3:0] p);
    case (m)
      4'h1: return {2'b00, p[2], p[0]};
      4'h2: return {2'b00, p[3], p[1]};
      4'h3: return {2'b00, p[1], p[0]};
      4'h4: return {2'b00, p[3], p[2]};
      4'h5: return {p[3], p[1], p[2], p[0]};
      default: return p;
    endcase
  endfunction

  task automatic nco_is(input logic [3:0] e);
    cyc(4);
    chk({28'h0, decim_o.nco_chan}, {28'h0, e});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    cyc(3);
    srst <= 1'b0;
    cyc(2);
    chk({12'h0, decim_o}, 32'h0);
    rdc(IDX_CTRL, 32'h0, RESP_OKAY);
    rdc(IDX_INSEL, 32'h0, RESP_OKAY);
    rdc(IDX_NCO, 32'h0, RESP_OKAY);
    rdc(10'h352, 32'h0, RESP_SLVERR);
    wr(10'h352, 8'h5a, RESP_SLVERR);
    $display("test reset done");
    for (int c = 0; c < 2; c++)
      for (int i = 0; i < 8; i++)
      begin
        wr(IDX_INSEL, {t_ext[i], 4'h0}, RESP_OKAY); // ext field
        wr(IDX_CTRL, {4'h0, c[0], t_main[i]}, RESP_OKAY); // main field
        cyc(2);
        ratio = (c == 1) ? (t_rat[i] >> 1) : t_rat[i];
        chk({18'h0, decim_o.valid, decim_o.real_only, decim_o.ratio, decim_o.stages},
          {18'h0, 1'b1, c[0], ratio, t_stg[i]}); // chain
      end
    wr(IDX_INSEL, 8'h50, RESP_OKAY);
    cyc(2);
    chk({31'h0, decim_o.valid}, 32'h0); // unlisted ext code
    $display("test decimation done");
    wr(IDX_INSEL, 8'hff, RESP_OKAY);
    rdc(IDX_INSEL, 32'hf5, RESP_OKAY); // reserved bits read zero
    wr(IDX_INSEL, 8'h04, RESP_OKAY);
    cyc(2);
    chk({30'h0, decim_o.q_sel, decim_o.i_sel}, 32'h2); // Q from B, I from A
    wr(IDX_INSEL, 8'h01, RESP_OKAY);
    cyc(2);
    chk({30'h0, decim_o.q_sel, decim_o.i_sel}, 32'h1); // I from B
    $display("test input select done");
    wr(IDX_NCO, 8'h05, RESP_OKAY);
    nco_is(4'h5); // field
    wr(IDX_NCO, 8'h01, RESP_OKAY);
    nco_is(4'h1); // field
    rdc(IDX_NCO, 32'h01, RESP_OKAY);
    for (int j = 0; j < 2; j++)
    begin
      @(posedge ref_clk);
      lvl <= t_pat[j];
      for (int m = 1; m < 7; m++)
      begin
        wr(IDX_NCO, {m[3:0], 4'h0}, RESP_OKAY);
        nco_is(pin_idx(m[3:0], t_pat[j])); // pins
      end
    end
    wr(IDX_NCO, 8'h70, RESP_OKAY);
    @(posedge ref_clk);
    lvl <= 4'h9;
    nco_is(4'h6); // reserved holds
    wr(IDX_NCO, 8'hc0, RESP_OKAY);
    nco_is(4'h6); // reserved holds
    $display("test pin modes done");
    @(posedge ref_clk);
    lvl <= 4'h0;
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_NCO, {4'h8 + m[3:0], 4'h2}, RESP_OKAY);
      for (int k = 0; k < 4; k++)
      begin
        pulse(m);
        ecnt = (ecnt >= 4'h2) ? 4'h0 : ecnt + 4'h1;
        nco_is(ecnt); // count and wrap
      end
      pulse((m + 1) % 4);
      nco_is(ecnt); // other pin ignored
    end
    $display("test edge modes done");
    @(posedge ref_clk);
    wstrb <= 4'h0;
    wr(IDX_NCO, 8'h33, RESP_OKAY);
    wstrb <= 4'h1;
    rdc(IDX_NCO, 32'hb2, RESP_OKAY);
    rdc(IDX_STAT, {8'h0, ecnt, 2'b11, 6'h18, STG_TB_HB4, 2'b01, ecnt}, RESP_OKAY); // status
    $display("test status done");
    results();
  end
endmodule
